// File: rtl/getc_edge_trigger.v
// Behaviour
// - A low-to-high pin transition with the rising enable set raises that pin's event output.
// - A high-to-low pin transition with the falling enable set raises that pin's event output.
// - The two enable vectors have no address and change only through their set and clear registers.
// - Writing 1 to bit n of rise_trigger_set sets bit n of the rising enable vector.
// - Writing 1 to bit n of rise_trigger_clear clears bit n of the rising enable vector.
// - Writing 1 to bit n of fall_trigger_set sets bit n of the falling enable vector.
// - Writing 0 to any bit of a set or clear register leaves the enable bit as it was.
// - Reading rise_trigger_set or rise_trigger_clear returns the rising enable vector in bits 15-0.
// - Reading fall_trigger_set returns the falling enable vector in bits 15-0.
// - Bits 31-16 of every trigger register read 0 and ignore writes.
// - Writing 1 to fall_trigger_clear clears falling enable bits, and reading it returns that vector.
`timescale 1ns/1ps
`include "getc_defines.vh"

// Register map, byte offsets on the APB port
//   0x000 rise_trigger_set    ones set rising enables, reads the rising vector
//   0x004 rise_trigger_clear  ones clear rising enables, reads the rising vector
//   0x008 fall_trigger_set    ones set falling enables, reads the falling vector
//   0x00C fall_trigger_clear  ones clear falling enables, reads the falling vector
//   0x010 event status        sticky per pin, write one to clear
//   0x014 event mask          per pin, gates the interrupt level
// Any other address answers with pslverr and reads zero.
// Timing: a pin change reaches pin_event_out two edges after it is first sampled, on the third edge counting the sampling edge.

module getc_edge_trigger #(
    parameter PINS = 16
) (
    input  wire              clk,
    input  wire              reset,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    input  wire [PINS-1:0]   general_pin,
    output reg  [PINS-1:0]   pin_event_out,
    output reg               irq
);

    // Register select decode, shared by read and write paths
    function is_addr;
        input [11:0] a;
        input [11:0] off;
        begin
            is_addr = (a == off);
        end
    endfunction

    // Hidden trigger enables, one flop per pin; no address reaches them directly
    wire [PINS-1:0]           rise_edge_enable_vector;
    wire [PINS-1:0]           fall_edge_enable_vector;

    // Pin sampling chain and the settle shifter that guards the first compares
    reg  [PINS-1:0]           pin_sync1_r;
    reg  [PINS-1:0]           pin_sync2_r;
    reg  [PINS-1:0]           pin_prev_r;
    reg  [`GETC_SETTLE_MSB:0] prev_valid_r;

    // Event bookkeeping, one bit per pin
    wire [PINS-1:0]           evt_status;
    wire [PINS-1:0]           evt_mask;

    // Bus decode
    wire [PINS-1:0]           wbits;
    wire                      access;
    wire                      wr;
    wire                      rd;
    wire                      mapped;
    wire                      sel_rise_set;
    wire                      sel_rise_clr;
    wire                      sel_fall_set;
    wire                      sel_fall_clr;
    wire                      sel_status;
    wire                      sel_mask;
    wire                      wr_rise_set;
    wire                      wr_rise_clr;
    wire                      wr_fall_set;
    wire                      wr_fall_clr;
    wire                      wr_status;
    wire                      wr_mask;
    wire [31:0]               rdata_nxt;

    // Edge detection and event paths
    wire                      compare_ok;
    wire [PINS-1:0]           rise_seen;
    wire [PINS-1:0]           fall_seen;
    wire [PINS-1:0]           rise_hit;
    wire [PINS-1:0]           fall_hit;
    wire [PINS-1:0]           evt_nxt;
    wire [PINS-1:0]           status_nxt;
    wire [PINS-1:0]           mask_nxt;
    wire                      irq_nxt;

    genvar gi;

    // Upper write bits are dropped here, so they never reach state
    assign wbits  = pwdata[PINS-1:0];

    // Only the first access-phase edge takes a transfer; the pready cycle must not repeat it
    assign access = psel & penable & ~pready;
    assign wr     = access & pwrite;
    assign rd     = access & ~pwrite;

    // One select per register word; nothing selects the enable vectors themselves
    assign sel_rise_set = is_addr(paddr, `GETC_OFF_RISE_SET);
    assign sel_rise_clr = is_addr(paddr, `GETC_OFF_RISE_CLR);
    assign sel_fall_set = is_addr(paddr, `GETC_OFF_FALL_SET);
    assign sel_fall_clr = is_addr(paddr, `GETC_OFF_FALL_CLR);
    assign sel_status   = is_addr(paddr, `GETC_OFF_EVT_STATUS);
    assign sel_mask     = is_addr(paddr, `GETC_OFF_EVT_MASK);
    assign mapped       = sel_rise_set | sel_rise_clr | sel_fall_set |
                          sel_fall_clr | sel_status | sel_mask;

    // Write strobes, each live for the single taking edge
    assign wr_rise_set = wr & sel_rise_set;
    assign wr_rise_clr = wr & sel_rise_clr;
    assign wr_fall_set = wr & sel_fall_set;
    assign wr_fall_clr = wr & sel_fall_clr;
    assign wr_status   = wr & sel_status;
    assign wr_mask     = wr & sel_mask;

    // Enable flops per pin; a 0 in the written word leaves the bit alone
    generate
        for (gi = 0; gi < PINS; gi = gi + 1) begin : g_enable
            reg rise_en_r;
            reg fall_en_r;

            // Set and clear strobes decode different words, so they never meet
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    rise_en_r <= `GETC_BIT_OFF;
                end else if (wr_rise_set && wbits[gi]) begin
                    rise_en_r <= `GETC_BIT_ON;
                end else if (wr_rise_clr && wbits[gi]) begin
                    rise_en_r <= `GETC_BIT_OFF;
                end
            end

            // Falling enable, same pattern on its own pair of words
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    fall_en_r <= `GETC_BIT_OFF;
                end else if (wr_fall_set && wbits[gi]) begin
                    fall_en_r <= `GETC_BIT_ON;
                end else if (wr_fall_clr && wbits[gi]) begin
                    fall_en_r <= `GETC_BIT_OFF;
                end
            end

            assign rise_edge_enable_vector[gi] = rise_en_r;
            assign fall_edge_enable_vector[gi] = fall_en_r;
        end
    endgenerate

    // Two-stage sampler plus previous copy; only stage two feeds the compare
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_sync1_r  <= `GETC_RST_VEC;
            pin_sync2_r  <= `GETC_RST_VEC;
            pin_prev_r   <= `GETC_RST_VEC;
            prev_valid_r <= `GETC_SETTLE_RST;
        end else begin
            pin_sync1_r  <= general_pin;
            pin_sync2_r  <= pin_sync1_r;
            pin_prev_r   <= pin_sync2_r;
            prev_valid_r <= {prev_valid_r[`GETC_SETTLE_MSB-1:0], `GETC_BIT_ON};
        end
    end

    // The previous copy holds its reset value until the third edge; a pin high
    // through reset would look like a rising edge if compared any sooner
    assign compare_ok = prev_valid_r[`GETC_SETTLE_MSB];

    // Edge compare per pin; either enabled direction drives the same event line
    generate
        for (gi = 0; gi < PINS; gi = gi + 1) begin : g_edge
            assign rise_seen[gi] = pin_sync2_r[gi] & ~pin_prev_r[gi];
            assign fall_seen[gi] = ~pin_sync2_r[gi] & pin_prev_r[gi];
            assign rise_hit[gi]  = rise_seen[gi] & rise_edge_enable_vector[gi];
            assign fall_hit[gi]  = fall_seen[gi] & fall_edge_enable_vector[gi];
            assign evt_nxt[gi]   = compare_ok & (rise_hit[gi] | fall_hit[gi]);
        end
    endgenerate

    // Sticky status and mask per pin; a new event wins over a same-cycle clear
    generate
        for (gi = 0; gi < PINS; gi = gi + 1) begin : g_status
            reg status_r;
            reg mask_r;

            assign status_nxt[gi] = evt_nxt[gi] | (status_r & ~(wr_status & wbits[gi]));
            assign mask_nxt[gi]   = wr_mask ? wbits[gi] : mask_r;

            // Status and mask flops
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    status_r <= `GETC_BIT_OFF;
                    mask_r   <= `GETC_BIT_OFF;
                end else begin
                    status_r <= status_nxt[gi];
                    mask_r   <= mask_nxt[gi];
                end
            end

            assign evt_status[gi] = status_r;
            assign evt_mask[gi]   = mask_r;
        end
    endgenerate

    // Interrupt level built from next values, so a mask write acts at the same edge
    assign irq_nxt = |(status_nxt & mask_nxt);

    // Event pulses and interrupt level
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_event_out <= `GETC_RST_VEC;
            irq           <= `GETC_BIT_OFF;
        end else begin
            pin_event_out <= evt_nxt;
            irq           <= irq_nxt;
        end
    end

    // Read word for the selected register; both words of a direction return its vector
    function [31:0] read_word;
        input [11:0]     a;
        input [PINS-1:0] rise_v;
        input [PINS-1:0] fall_v;
        input [PINS-1:0] stat_v;
        input [PINS-1:0] mask_v;
        begin
            case (a)
                `GETC_OFF_RISE_SET:   read_word = {`GETC_ZERO_HI, rise_v};
                `GETC_OFF_RISE_CLR:   read_word = {`GETC_ZERO_HI, rise_v};
                `GETC_OFF_FALL_SET:   read_word = {`GETC_ZERO_HI, fall_v};
                `GETC_OFF_FALL_CLR:   read_word = {`GETC_ZERO_HI, fall_v};
                `GETC_OFF_EVT_STATUS: read_word = {`GETC_ZERO_HI, stat_v};
                `GETC_OFF_EVT_MASK:   read_word = {`GETC_ZERO_HI, mask_v};
                default:              read_word = `GETC_RST_DATA;
            endcase
        end
    endfunction

    assign rdata_nxt = read_word(paddr, rise_edge_enable_vector, fall_edge_enable_vector,
                                 evt_status, evt_mask);

    // APB answer: one wait state, pready pulses for one cycle per transfer
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pready  <= `GETC_BIT_OFF;
            pslverr <= `GETC_BIT_OFF;
            prdata  <= `GETC_RST_DATA;
        end else begin
            pready  <= access;
            pslverr <= access & ~mapped;
            prdata  <= rd ? rdata_nxt : `GETC_RST_DATA;                        // Zero outside the answer cycle
        end
    end

endmodule // getc_edge_trigger

// File: rtl/getc_defines.vh
`ifndef GETC_DEFINES_VH
`define GETC_DEFINES_VH

// Register byte offsets on the APB port
`define GETC_OFF_RISE_SET    12'h000
`define GETC_OFF_RISE_CLR    12'h004
`define GETC_OFF_FALL_SET    12'h008
`define GETC_OFF_FALL_CLR    12'h00C
`define GETC_OFF_EVT_STATUS  12'h010
`define GETC_OFF_EVT_MASK    12'h014

// Reset values
`define GETC_RST_VEC         16'h0000
`define GETC_RST_DATA        32'h0000_0000

// Upper bits above the pin field read as zero
`define GETC_ZERO_HI         16'h0000

// Single-bit flop values
`define GETC_BIT_OFF         1'h0
`define GETC_BIT_ON          1'h1

// Settle shifter: compares start once the previous copy holds a real sample
`define GETC_SETTLE_MSB      2
`define GETC_SETTLE_RST      3'h0

`endif

// File: test/getc_chk.sv
`timescale 1ns/1ps
module getc_chk #(
    parameter PINS = 16
) (
    input wire logic            clk, reset, psel, penable, pwrite, pready, pslverr, irq,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     pwdata, prdata,
    input wire logic [PINS-1:0] general_pin, pin_event_out
);
    // One clock domain; reset silences every check
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_ready_next: assert property (psel && penable && !pready |=> pready) else $error("late ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready stuck");
    a_idle_rdata: assert property (!pready |-> prdata == 0) else $error("stray read data");
    a_high_zero: assert property (pready |-> prdata[31:16] == 0) else $error("upper bits set");
    a_unmapped_err: assert property (pready |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'b00))
        else $error("bad error");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    // An event must trace back to a pin change three edges earlier
    a_event_edge: assert property (|pin_event_out |->
        (pin_event_out & ~($past(general_pin, 3) ^ $past(general_pin, 4))) == 0) else $error("event w/o edge");
    a_event_single: assert property (|pin_event_out |=> (pin_event_out & $past(pin_event_out)) == 0)
        else $error("long event");
    a_reset_quiet: assert property ($past(reset) |-> pin_event_out == 0 && !irq) else $error("noisy reset");
endmodule // getc_chk

bind getc_edge_trigger getc_chk #(.PINS(PINS)) chk (.*);

// File: test/getc_pin_drv.sv
`timescale 1ns/1ps
module getc_pin_drv (
    input wire logic         clk,
    input wire logic [15:0]  want,
    output logic [15:0]      general_pin = 16'h0000
);
    // Pins move just after an edge, like a board signal settling between clocks
    always @(posedge clk) general_pin <= want;
endmodule // getc_pin_drv

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic [15:0] want = 16'h0000, general_pin, pin_event_out, seen;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    initial forever #5 clk = ~clk;
    getc_edge_trigger dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .general_pin(general_pin), .pin_event_out(pin_event_out), .irq(irq));
    getc_pin_drv pins (.clk(clk), .want(want), .general_pin(general_pin));
    // Sticky copy of the pulses, so a one-cycle event is never missed
    always @(posedge clk) seen <= reset ? 16'h0000 : seen | pin_event_out;
    // Hang guard: the whole run needs under two hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            test_done;
        end
    end
    task apb(input bit w, input [11:0] a, input [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task cmp(input [31:0] g, input [31:0] x);
        cmp_count++;
        if (g !== x) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask
    task rd(input [11:0] a, input [31:0] x);
        apb(0, a, 32'h0000_0000);
        cmp(q, x);
    endtask
    task t_regs;
        for (int i = 0; i < 24; i += 4) rd(i[11:0], 32'h0000_0000);
        apb(1, 12'h000, 32'hffff_00a5);
        rd(12'h000, 32'h0000_00a5);
        rd(12'h004, 32'h0000_00a5);
        apb(1, 12'h004, 32'h0000_0005);
        rd(12'h004, 32'h0000_00a0);
        apb(1, 12'h008, 32'h0000_0003);
        rd(12'h008, 32'h0000_0003);
        apb(1, 12'h00c, 32'h0001_0001);
        rd(12'h00c, 32'h0000_0002);
        rd(12'h100, 32'h0000_0000);
        cmp(32'(e), 32'h0000_0001);
    endtask
    task t_edges;
        apb(1, 12'h014, 32'h0000_ffff);
        want <= 16'h0022;
        repeat (8) @(posedge clk);
        cmp(32'(seen), 32'h0000_0020);
        cmp(32'(irq), 32'h0000_0001);
        rd(12'h010, 32'h0000_0020);
        apb(1, 12'h010, 32'h0000_0020);
        want <= 16'h0000;
        repeat (8) @(posedge clk);
        cmp(32'(seen), 32'h0000_0022);
        rd(12'h010, 32'h0000_0002);
        apb(1, 12'h014, 32'h0000_0000);
        repeat (2) @(posedge clk);
        cmp(32'(irq), 32'h0000_0000);
    endtask
    task t_both;
        apb(1, 12'h008, 32'h0000_0020);
        apb(1, 12'h010, 32'h0000_ffff);
        want <= 16'h0020;
        repeat (8) @(posedge clk);
        rd(12'h010, 32'h0000_0020);
        apb(1, 12'h010, 32'h0000_0020);
        want <= 16'h0000;
        repeat (8) @(posedge clk);
        rd(12'h010, 32'h0000_0020);
    endtask
    task t_reset;
        want <= 16'h0001;
        repeat (4) @(posedge clk);
        reset <= 1;
        repeat (2) @(posedge clk);
        reset <= 0;
        repeat (8) @(posedge clk);
        cmp(32'(seen), 32'h0000_0000);
        rd(12'h000, 32'h0000_0000);
        rd(12'h008, 32'h0000_0000);
        apb(1, 12'h000, 32'h0000_0001);
        want <= 16'h0000;
        repeat (8) @(posedge clk);
        cmp(32'(seen), 32'h0000_0000);
        want <= 16'h0001;
        repeat (8) @(posedge clk);
        cmp(32'(seen), 32'h0000_0001);
    endtask
    task test_done;
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset <= 0;
        t_regs;
        t_edges;
        t_both;
        t_reset;
        test_done;
    end
endmodule // tb
